// ==== rtl/psc_pkg.sv ====
// Constants, offsets and types shared by the position switch comparator files.
package psc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Geometry of the switch bank.
    localparam int PSC_NUM_SW       = 8;
    localparam int PSC_NUM_PS       = 2;
    localparam int PSC_NUM_CMP      = PSC_NUM_SW * PSC_NUM_PS;
    localparam int PSC_NUM_NC_AXES  = 9;
    localparam int PSC_NUM_PLC_AXES = 8;
    localparam int PSC_POS_W        = 32;
    localparam int PSC_AXIS_W       = 5;
    localparam int PSC_FIRST_SW     = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Position limits in 0.001 mm steps.
    localparam logic [31:0] PSC_POS_MAX = 32'h05f5e0ff;
    localparam logic [31:0] PSC_POS_MIN = 32'hfa0a1f01;

    ////////////////////////////////////////////////////////////////////////////////
    // Axis codes: 0 to 8 are X, Y, Z, U, V, W, A, B, C; 9 to 16 are PLC axes 1 to 8.
    localparam logic [4:0] PSC_AXIS_PLC_BASE = 5'h09;
    localparam logic [4:0] PSC_AXIS_LAST     = 5'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [11:0] PSC_CTRL_OFF   = 12'h000;
    localparam logic [11:0] PSC_STATUS_OFF = 12'h004;
    localparam logic [11:0] PSC_MASK_OFF   = 12'h008;
    localparam logic [11:0] PSC_LIVE_OFF   = 12'h00c;
    localparam logic [2:0]  PSC_SW_REGION  = 3'h1;
    localparam logic [2:0]  PSC_MON_REGION = 3'h2;
    localparam logic [1:0]  PSC_FLD_AXIS   = 2'h0;
    localparam logic [1:0]  PSC_FLD_LIMA   = 2'h1;
    localparam logic [1:0]  PSC_FLD_LIMB   = 2'h2;
    localparam logic [1:0]  PSC_FLD_CHECK  = 2'h3;
    localparam int          PSC_CTRL_HS_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [4:0]  PSC_AXIS_RST  = 5'h00;
    localparam logic [31:0] PSC_LIM_RST   = 32'h00000000;
    localparam logic        PSC_CHECK_RST = 1'b0;
    localparam logic        PSC_CTRL_RST  = 1'b0;
    localparam logic [15:0] PSC_FLAG_RST  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Register selection on the bus.
    typedef enum logic [2:0] {
        PSC_SEL_NONE,
        PSC_SEL_CTRL,
        PSC_SEL_STATUS,
        PSC_SEL_MASK,
        PSC_SEL_LIVE,
        PSC_SEL_SW,
        PSC_SEL_MON
    } psc_sel_t;

endpackage : psc_pkg

// ==== rtl/psc_cmp_if.sv ====
// Interface carrying compare operands and results between the top and the comparator.
`timescale 1ns/1ps
interface psc_cmp_if #(
    parameter int N = 16,
    parameter int W = 32
);
    logic signed [W-1:0] pos   [N];
    logic signed [W-1:0] lim_a [N];
    logic signed [W-1:0] lim_b [N];
    logic        [N-1:0] en;
    logic        [N-1:0] hit;

    modport top (output pos, output lim_a, output lim_b, output en, input hit);
    modport cmp (input pos, input lim_a, input lim_b, input en, output hit);
endinterface : psc_cmp_if

// ==== rtl/psc_window_cmp.sv ====
// Window comparators, one per switch and part system, with registered results.
`timescale 1ns/1ps
module psc_window_cmp
    import psc_pkg::*;
#(
    parameter int N = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    psc_cmp_if.cmp   cmp
);

    logic [N-1:0] in_range;

    ////////////////////////////////////////////////////////////////////////////////
    // Inclusive window between the smaller and the larger limit.
    for (genvar i = 0; i < N; i++) begin : g_cmp
        logic signed [PSC_POS_W-1:0] lo;
        logic signed [PSC_POS_W-1:0] hi;
        assign lo = (cmp.lim_a[i] < cmp.lim_b[i]) ? cmp.lim_a[i] : cmp.lim_b[i];
        assign hi = (cmp.lim_a[i] < cmp.lim_b[i]) ? cmp.lim_b[i] : cmp.lim_a[i];
        assign in_range[i] = cmp.en[i] && (cmp.pos[i] >= lo) && (cmp.pos[i] <= hi);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp.hit <= '0;
        end else begin
            cmp.hit <= in_range;
        end
    end

endmodule : psc_window_cmp

// ==== rtl/psc_top.sv ====
// Position switch bank for switches 4 to 11 in two part systems, with an APB register file.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - A switch output is high while its axis position lies within its two virtual limits.
// - Part system 1 drives one output bit per switch, switch 4 on bit 0 up to switch 11 on bit 7.
// - Part system 2 drives one output bit per switch, switch 4 on bit 0 up to switch 11 on bit 7.
// - Each virtual limit is a signed count of 0.001 mm held within plus or minus 99999.999 mm.
// - With check selector 0 the commanded machine position is compared.
// - With check selector 1 the detector feedback position is compared.
// - The check selector acts only under high-speed checking and is held per switch.
// - Each switch is assigned one axis, an NC axis X to C or a PLC axis 1 to 8.
module psc_top
    import psc_pkg::*;
(
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    input  wire logic [3:0]                            pstrb,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [PSC_NUM_NC_AXES*PSC_POS_W-1:0]  ps1_cmd_pos,
    input  wire logic [PSC_NUM_NC_AXES*PSC_POS_W-1:0]  ps1_fb_pos,
    input  wire logic [PSC_NUM_NC_AXES*PSC_POS_W-1:0]  ps2_cmd_pos,
    input  wire logic [PSC_NUM_NC_AXES*PSC_POS_W-1:0]  ps2_fb_pos,
    input  wire logic [PSC_NUM_PLC_AXES*PSC_POS_W-1:0] plc_axis_pos,
    output logic      [PSC_NUM_SW-1:0]                 ps1_switch_out,
    output logic      [PSC_NUM_SW-1:0]                 ps2_switch_out,
    output logic                                       irq
);

    localparam int N = PSC_NUM_CMP;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic psc_sel_t psc_decode(input logic [11:0] addr);
        psc_sel_t sel;
        sel = PSC_SEL_NONE;
        if (addr[1:0] != 2'h0) begin
            sel = PSC_SEL_NONE;
        end else if (addr == PSC_CTRL_OFF) begin
            sel = PSC_SEL_CTRL;
        end else if (addr == PSC_STATUS_OFF) begin
            sel = PSC_SEL_STATUS;
        end else if (addr == PSC_MASK_OFF) begin
            sel = PSC_SEL_MASK;
        end else if (addr == PSC_LIVE_OFF) begin
            sel = PSC_SEL_LIVE;
        end else if (addr[11:9] == PSC_SW_REGION && !addr[7]) begin
            sel = PSC_SEL_SW;
        end else if (addr[11:9] == PSC_MON_REGION && !addr[7] && addr[3:2] == 2'h0) begin
            sel = PSC_SEL_MON;
        end
        return sel;
    endfunction : psc_decode

    function automatic logic [31:0] psc_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return r;
    endfunction : psc_merge

    function automatic logic [31:0] psc_sat(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if ($signed(v) > $signed(PSC_POS_MAX)) begin
            r = PSC_POS_MAX;
        end else if ($signed(v) < $signed(PSC_POS_MIN)) begin
            r = PSC_POS_MIN;
        end
        return r;
    endfunction : psc_sat

    function automatic logic [31:0] psc_pick(
        input logic [PSC_AXIS_W-1:0]                axis,
        input logic                                 use_fb,
        input logic [PSC_NUM_NC_AXES*PSC_POS_W-1:0]  cmd,
        input logic [PSC_NUM_NC_AXES*PSC_POS_W-1:0]  fb,
        input logic [PSC_NUM_PLC_AXES*PSC_POS_W-1:0] plc);
        logic [31:0] r;
        int          k;
        r = 32'h00000000;
        k = int'(axis);
        if (axis < PSC_AXIS_PLC_BASE) begin
            r = use_fb ? fb[k*PSC_POS_W +: PSC_POS_W] : cmd[k*PSC_POS_W +: PSC_POS_W];
        end else if (axis <= PSC_AXIS_LAST) begin
            r = plc[(k - int'(PSC_AXIS_PLC_BASE))*PSC_POS_W +: PSC_POS_W];
        end
        return r;
    endfunction : psc_pick

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic                  hs_check_reg;
    logic [N-1:0]          status_reg;
    logic [N-1:0]          mask_reg;
    logic [N-1:0]          hit_d_reg;
    logic [PSC_AXIS_W-1:0] axis_reg  [N];
    logic [31:0]           lim_a_reg [N];
    logic [31:0]           lim_b_reg [N];
    logic                  check_reg [N];
    logic [31:0]           prdata_reg;
    logic                  pslverr_reg;
    logic [31:0]           prdata_next;
    logic                  pslverr_next;
    logic [N-1:0]          hit;
    logic [N-1:0]          rise;
    logic [N-1:0]          clr;
    logic [31:0]           mon_pos   [N];

    psc_sel_t     wr_sel;
    psc_sel_t     rd_sel;
    logic         wr_en;
    logic [3:0]   wr_idx;
    logic [3:0]   rd_idx;
    logic [1:0]   wr_fld;
    logic [1:0]   rd_fld;

    assign wr_en  = psel && penable && pwrite;
    assign wr_sel = psc_decode(paddr);
    assign rd_sel = psc_decode(paddr);
    assign wr_idx = {paddr[8], paddr[6:4]};
    assign rd_idx = {paddr[8], paddr[6:4]};
    assign wr_fld = paddr[3:2];
    assign rd_fld = paddr[3:2];

    ////////////////////////////////////////////////////////////////////////////////
    // Control and mask registers.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_check_reg <= PSC_CTRL_RST;
            mask_reg     <= PSC_FLAG_RST;
        end else if (wr_en && wr_sel == PSC_SEL_CTRL && pstrb[0]) begin
            hs_check_reg <= pwdata[PSC_CTRL_HS_BIT];
        end else if (wr_en && wr_sel == PSC_SEL_MASK) begin
            mask_reg <= N'(psc_merge({16'h0000, mask_reg}, pwdata, pstrb));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-switch settings.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                axis_reg[i]  <= PSC_AXIS_RST;
                lim_a_reg[i] <= PSC_LIM_RST;
                lim_b_reg[i] <= PSC_LIM_RST;
                check_reg[i] <= PSC_CHECK_RST;
            end
        end else if (wr_en && wr_sel == PSC_SEL_SW) begin
            case (wr_fld)
                PSC_FLD_AXIS: begin
                    if (pstrb[0]) begin
                        axis_reg[wr_idx] <= pwdata[PSC_AXIS_W-1:0];
                    end
                end
                PSC_FLD_LIMA: begin
                    lim_a_reg[wr_idx] <= psc_sat(psc_merge(lim_a_reg[wr_idx], pwdata, pstrb));
                end
                PSC_FLD_LIMB: begin
                    lim_b_reg[wr_idx] <= psc_sat(psc_merge(lim_b_reg[wr_idx], pwdata, pstrb));
                end
                default: begin
                    if (pstrb[0]) begin
                        check_reg[wr_idx] <= pwdata[0];
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Position selection and comparison.

    psc_cmp_if #(.N(N), .W(PSC_POS_W)) cmp_bus ();

    for (genvar i = 0; i < N; i++) begin : g_sel
        logic use_fb;
        assign use_fb = hs_check_reg && check_reg[i];
        if (i < PSC_NUM_SW) begin : g_ps1
            assign mon_pos[i] = psc_pick(axis_reg[i], use_fb, ps1_cmd_pos, ps1_fb_pos,
                                         plc_axis_pos);
        end else begin : g_ps2
            assign mon_pos[i] = psc_pick(axis_reg[i], use_fb, ps2_cmd_pos, ps2_fb_pos,
                                         plc_axis_pos);
        end
        assign cmp_bus.pos[i]   = mon_pos[i];
        assign cmp_bus.lim_a[i] = lim_a_reg[i];
        assign cmp_bus.lim_b[i] = lim_b_reg[i];
        assign cmp_bus.en[i]    = (axis_reg[i] <= PSC_AXIS_LAST);
    end

    psc_window_cmp #(.N(N)) u_cmp (
        .pclk    (pclk),
        .presetn (presetn),
        .cmp     (cmp_bus.cmp)
    );

    assign hit            = cmp_bus.hit;
    assign ps1_switch_out = hit[PSC_NUM_SW-1:0];
    assign ps2_switch_out = hit[N-1:PSC_NUM_SW];

    ////////////////////////////////////////////////////////////////////////////////
    // Entry events and interrupt.

    assign rise = hit & ~hit_d_reg;
    assign clr  = (wr_en && wr_sel == PSC_SEL_STATUS) ?
                  N'(psc_merge(32'h00000000, pwdata, pstrb)) : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_d_reg <= PSC_FLAG_RST;
        end else begin
            hit_d_reg <= hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= PSC_FLAG_RST;
        end else begin
            status_reg <= (status_reg & ~clr) | rise;
        end
    end

    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Read path, captured in the setup phase.

    always_comb begin
        prdata_next  = 32'h00000000;
        pslverr_next = 1'b0;
        case (rd_sel)
            PSC_SEL_CTRL: begin
                prdata_next[PSC_CTRL_HS_BIT] = hs_check_reg;
            end
            PSC_SEL_STATUS: begin
                prdata_next[N-1:0] = status_reg;
            end
            PSC_SEL_MASK: begin
                prdata_next[N-1:0] = mask_reg;
            end
            PSC_SEL_LIVE: begin
                prdata_next[N-1:0] = hit;
            end
            PSC_SEL_SW: begin
                if (rd_fld == PSC_FLD_AXIS) begin
                    prdata_next[PSC_AXIS_W-1:0] = axis_reg[rd_idx];
                end else if (rd_fld == PSC_FLD_LIMA) begin
                    prdata_next = lim_a_reg[rd_idx];
                end else if (rd_fld == PSC_FLD_LIMB) begin
                    prdata_next = lim_b_reg[rd_idx];
                end else begin
                    prdata_next[0] = check_reg[rd_idx];
                end
            end
            PSC_SEL_MON: begin
                prdata_next = mon_pos[rd_idx];
            end
            default: begin
                pslverr_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign pready  = 1'b1;

endmodule : psc_top

// ==== dv/psc_top_sva.sv ====
// Assertion checker for the switch outputs of the position switch comparator.
`timescale 1ns/1ps
module psc_top_sva
    import psc_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [287:0] ps1_cmd_pos,
    input wire logic [287:0] ps1_fb_pos,
    input wire logic [287:0] ps2_cmd_pos,
    input wire logic [287:0] ps2_fb_pos,
    input wire logic [255:0] plc_axis_pos,
    input wire logic [7:0]   ps1_switch_out,
    input wire logic [7:0]   ps2_switch_out
);
    logic [4:0]         ax_reg [16];
    logic signed [31:0] la_reg [16];
    logic signed [31:0] lb_reg [16];
    logic [15:0]        ck_reg;
    logic               hs_reg;
    logic [15:0]        hc, hf, sel, bad, swp, eh, sw_out;
    logic signed [31:0] wv;
    logic [3:0]         ix;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the switch settings, saturated as the device stores them.
    assign ix = {paddr[8], paddr[6:4]};
    assign wv = ($signed(pwdata) > $signed(PSC_POS_MAX)) ? PSC_POS_MAX :
                ($signed(pwdata) < $signed(PSC_POS_MIN)) ? PSC_POS_MIN : pwdata;
    assign sw_out = {ps2_switch_out, ps1_switch_out};
    assign eh = (sel & hf) | (~sel & hc);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                ax_reg[i] <= PSC_AXIS_RST;
                la_reg[i] <= PSC_LIM_RST;
                lb_reg[i] <= PSC_LIM_RST;
            end
            ck_reg <= 16'h0000;
            hs_reg <= PSC_CTRL_RST;
        end else if (psel && penable && pwrite) begin
            if (paddr == PSC_CTRL_OFF) begin
                hs_reg <= pwdata[0];
            end
            if (paddr[11:9] == PSC_SW_REGION && !paddr[7] && paddr[1:0] == 2'h0) begin
                case (paddr[3:2])
                    PSC_FLD_AXIS: ax_reg[ix] <= pwdata[4:0];
                    PSC_FLD_LIMA: la_reg[ix] <= wv;
                    PSC_FLD_LIMB: lb_reg[ix] <= wv;
                    default:      ck_reg[ix] <= pwdata[0];
                endcase
            end
        end
    end
    function automatic logic signed [31:0] pick(logic [4:0] x, logic [287:0] v,
                                                logic [255:0] q);
        return (x < PSC_AXIS_PLC_BASE) ? v[x*32+:32] : q[(x-PSC_AXIS_PLC_BASE)*32+:32];
    endfunction : pick
    function automatic logic inw(logic signed [31:0] p, logic signed [31:0] a,
                                 logic signed [31:0] b);
        return (a <= b) ? (p >= a && p <= b) : (p >= b && p <= a);
    endfunction : inw
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            sel[i] = hs_reg & ck_reg[i];
            bad[i] = ax_reg[i] > PSC_AXIS_LAST;
            swp[i] = la_reg[i] > lb_reg[i];
            hc[i] = !bad[i] && inw(pick(ax_reg[i], i < 8 ? ps1_cmd_pos : ps2_cmd_pos,
                                        plc_axis_pos), la_reg[i], lb_reg[i]);
            hf[i] = !bad[i] && inw(pick(ax_reg[i], i < 8 ? ps1_fb_pos : ps2_fb_pos,
                                        plc_axis_pos), la_reg[i], lb_reg[i]);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Properties.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ps1; $past(presetn) |-> ps1_switch_out == $past(eh[7:0]); endproperty
    a_ps1: assert property (p_ps1) else $error("part system 1 outputs wrong");
    property p_ps2; $past(presetn) |-> ps2_switch_out == $past(eh[15:8]); endproperty
    a_ps2: assert property (p_ps2) else $error("part system 2 outputs wrong");
    property p_rise; $rose(ps1_switch_out[0]) |-> $past(eh[0]); endproperty
    a_rise: assert property (p_rise) else $error("output rose outside range");
    property p_cmd; $past(presetn) |-> ((sw_out ^ $past(hc)) & ~$past(sel)) == 16'h0; endproperty
    a_cmd: assert property (p_cmd) else $error("commanded compare wrong");
    property p_fb; $past(presetn) |-> ((sw_out ^ $past(hf)) & $past(sel)) == 16'h0; endproperty
    a_fb: assert property (p_fb) else $error("feedback compare wrong");
    property p_hs; $past(presetn) && !$past(hs_reg) |-> sw_out == $past(hc); endproperty
    a_hs: assert property (p_hs) else $error("selector acted without high speed");
    property p_swap; $past(presetn) |-> ((sw_out ^ $past(eh)) & $past(swp)) == 16'h0; endproperty
    a_swap: assert property (p_swap) else $error("swapped limits wrong");
    property p_axis; (sw_out & $past(bad)) == 16'h0; endproperty
    a_axis: assert property (p_axis) else $error("disabled switch high");
endmodule : psc_top_sva
bind psc_top psc_top_sva psc_top_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .ps1_cmd_pos, .ps1_fb_pos, .ps2_cmd_pos, .ps2_fb_pos, .plc_axis_pos,
    .ps1_switch_out, .ps2_switch_out);

// ==== dv/psc_plc_model.sv ====
// Model of the PLC that scans the switch output bits into its input image.
`timescale 1ns/1ps
module psc_plc_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  ps1_bits,
    input wire logic [7:0]  ps2_bits,
    output logic     [15:0] image_reg
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image_reg <= 16'h0000;
        end else begin
            image_reg <= {ps2_bits, ps1_bits};
        end
    end
endmodule : psc_plc_model

// ==== dv/position_switch_comparator_tb.sv ====
// Self-checking bench for the position switch comparator.
`timescale 1ns/1ps
module position_switch_comparator_tb
    import psc_pkg::*;
;
    typedef struct packed {
        logic [3:0]  sw;
        logic [4:0]  ax;
        logic [31:0] a, b, c, f;
        logic        ck, hs, hit;
    } psc_row_t;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [3:0]   pstrb = 4'hf;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, irq, er;
    logic [287:0] ps1_cmd_pos = '0, ps1_fb_pos = '0, ps2_cmd_pos = '0, ps2_fb_pos = '0;
    logic [255:0] plc_axis_pos = '0;
    logic [7:0]   ps1_switch_out, ps2_switch_out;
    logic [15:0]  image_reg;
    wire  [15:0]  sw_out = {ps2_switch_out, ps1_switch_out};
    int           n_errors = 0;
    int           n_compared = 0;
    psc_row_t     rows [12] = '{
        '{4'h0, 5'h00, 32'h64, 32'hc8, 32'h96, 32'h0, 1'b0, 1'b0, 1'b1},
        '{4'h0, 5'h00, 32'h64, 32'hc8, 32'h64, 32'h0, 1'b0, 1'b0, 1'b1},
        '{4'h0, 5'h00, 32'h64, 32'hc8, 32'hc9, 32'h0, 1'b0, 1'b0, 1'b0},
        '{4'h8, 5'h01, 32'hc8, 32'h64, 32'hc8, 32'h0, 1'b0, 1'b0, 1'b1},
        '{4'h8, 5'h01, 32'hc8, 32'h64, 32'h63, 32'h0, 1'b0, 1'b0, 1'b0},
        '{4'h3, 5'h02, 32'hffffffce, 32'h32, 32'h0, 32'h1f4, 1'b1, 1'b1, 1'b0},
        '{4'h3, 5'h02, 32'hffffffce, 32'h32, 32'h1f4, 32'hffffffce, 1'b1, 1'b1, 1'b1},
        '{4'h3, 5'h02, 32'hffffffce, 32'h32, 32'h0, 32'h1f4, 1'b1, 1'b0, 1'b1},
        '{4'h5, 5'h02, 32'hffffffce, 32'h32, 32'h0, 32'h1f4, 1'b0, 1'b1, 1'b1},
        '{4'h7, 5'h09, PSC_POS_MIN, PSC_POS_MAX, PSC_POS_MIN, 32'h0, 1'b0, 1'b0, 1'b1},
        '{4'hf, 5'h10, 32'h0, 32'ha, 32'hb, 32'h0, 1'b0, 1'b0, 1'b0},
        '{4'hc, 5'h11, 32'hfffffff6, 32'ha, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0}};
    always #5 pclk = ~pclk;
    psc_top psc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .ps1_cmd_pos, .ps1_fb_pos, .ps2_cmd_pos, .ps2_fb_pos,
        .plc_axis_pos, .ps1_switch_out, .ps2_switch_out, .irq);
    psc_plc_model psc_plc_model_inst (.pclk, .presetn, .ps1_bits(ps1_switch_out),
        .ps2_bits(ps2_switch_out), .image_reg);
    ////////////////////////////////////////////////////////////////////////////////
    // Tasks.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    function automatic logic [11:0] swa(input int s, input int f);
        return 12'h200 + 12'(s / 8 * 256 + s % 8 * 16 + f * 4);
    endfunction : swa
    task automatic cfg(input int s, input logic [4:0] ax, input logic [31:0] a,
                       input logic [31:0] b, input logic ck);
        wr(swa(s, 0), {27'h0, ax});
        wr(swa(s, 1), a);
        wr(swa(s, 2), b);
        wr(swa(s, 3), {31'h0, ck});
    endtask : cfg
    task automatic setp(input int s, input logic [4:0] ax, input logic [31:0] c,
                        input logic [31:0] f);
        if (ax < PSC_AXIS_PLC_BASE) begin
            if (s < 8) begin
                ps1_cmd_pos[ax*32+:32] <= c;
                ps1_fb_pos[ax*32+:32] <= f;
            end else begin
                ps2_cmd_pos[ax*32+:32] <= c;
                ps2_fb_pos[ax*32+:32] <= f;
            end
        end else if (ax <= PSC_AXIS_LAST) begin
            plc_axis_pos[(ax-PSC_AXIS_PLC_BASE)*32+:32] <= c;
        end
    endtask : setp
    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus.
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            wr(PSC_CTRL_OFF, {31'h0, rows[i].hs});
            cfg(rows[i].sw, rows[i].ax, rows[i].a, rows[i].b, rows[i].ck);
            setp(rows[i].sw, rows[i].ax, rows[i].c, rows[i].f);
            repeat (3) @(posedge pclk);
            chk(sw_out[rows[i].sw], rows[i].hit);
            chk(image_reg[rows[i].sw], rows[i].hit);
        end
        wr(PSC_CTRL_OFF, 32'h0);
        cfg(0, 5'h00, 32'h309, 32'h309, 1'b0);
        for (int a = 0; a <= 16; a++) begin
            wr(swa(0, 0), 32'(a));
            setp(0, 5'(a), 32'h309, 32'h0);
            repeat (2) @(posedge pclk);
            chk(sw_out[0], 1'b1);
            setp(0, 5'(a), 32'h0, 32'h0);
        end
        for (int i = 0; i < 16; i++) wr(swa(i, 0), 32'h1f);
        repeat (2) @(posedge pclk);
        chk(sw_out, 32'h0);
        for (int i = 0; i < 16; i++) begin
            cfg(i, 5'h00, 32'h309, 32'h309, 1'b0);
            setp(i, 5'h00, 32'h309, 32'h0);
            repeat (2) @(posedge pclk);
            chk(sw_out, 32'h1 << i);
            wr(swa(i, 0), 32'h1f);
        end
        wr(swa(0, 1), 32'h7fffffff);
        apb(1'b0, swa(0, 1), 32'h0);
        chk(rd, PSC_POS_MAX);
        wr(swa(0, 1), 32'h80000000);
        apb(1'b0, swa(0, 1), 32'h0);
        chk(rd, PSC_POS_MIN);
        setp(0, 5'h00, 32'h0, 32'h0);
        cfg(0, 5'h00, 32'h309, 32'h309, 1'b0);
        wr(PSC_STATUS_OFF, 32'hffff);
        wr(PSC_MASK_OFF, 32'h1);
        chk(irq, 1'b0);
        setp(0, 5'h00, 32'h309, 32'h0);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, PSC_STATUS_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h400, 32'h0);
        chk(rd, 32'h309);
        wr(PSC_STATUS_OFF, 32'h1);
        chk(irq, 1'b0);
        wr(PSC_MASK_OFF, 32'h0);
        setp(0, 5'h00, 32'h0, 32'h0);
        repeat (2) @(posedge pclk);
        setp(0, 5'h00, 32'h309, 32'h0);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, PSC_STATUS_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'hff0, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        presetn <= 1'b0;
        setp(0, 5'h00, 32'h0, 32'h0);
        setp(8, 5'h00, 32'h0, 32'h0);
        repeat (2) @(posedge pclk);
        chk({irq, sw_out}, 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(sw_out, 32'hffff);
        apb(1'b0, swa(3, 2), 32'h0);
        chk(rd, PSC_LIM_RST);
        chk(pready, 1'b1);
        finish_test();
    end
endmodule : position_switch_comparator_tb
